// ---- charger_regs_pkg.sv ----
// Shared constants and types for the charger timer and over-voltage register bank
package charger_regs_pkg;

    localparam logic [7:0] TMR_THERM_ADDR       = 8'h05;
    localparam logic [7:0] OVP_TEST_ADDR        = 8'h06;

    localparam int         SLOWDOWN_BIT         = 7;
    localparam int         LIMIT_HI_BIT         = 6;
    localparam int         LIMIT_LO_BIT         = 5;
    localparam int         DISCONNECT_BIT       = 4;
    localparam int         THERM_DIS_BIT        = 3;
    localparam int         OVP_MSB              = 7;
    localparam int         OVP_LSB              = 5;
    localparam int         DPLUS_BIT            = 4;
    localparam int         BATDET_BIT           = 3;
    localparam int         TEST_REQ_BIT         = 2;
    localparam int         SPARE_MSB            = 1;

    // Live status bits of the first register reset as zero in storage
    localparam logic [7:0] TMR_THERM_RESET      = 8'ha8;
    localparam logic [7:0] OVP_TEST_RESET_HOST  = 8'h20;
    localparam logic [7:0] OVP_TEST_RESET_PIN   = 8'he0;

    localparam logic [2:0] TS_NORMAL            = 3'h0;
    localparam logic [2:0] TS_BELOW_COLD        = 3'h4;
    localparam logic [2:0] TS_COLD_ZONE         = 3'h5;
    localparam logic [2:0] TS_BELOW_FREEZE      = 3'h6;
    localparam logic [2:0] TS_OPEN              = 3'h7;

    localparam logic [1:0] LIMIT_45MIN          = 2'h0;
    localparam logic [1:0] LIMIT_6H             = 2'h1;
    localparam logic [1:0] LIMIT_9H             = 2'h2;
    localparam logic [1:0] LIMIT_OFF            = 2'h3;

    localparam int         LIMIT_45MIN_MIN      = 45;
    localparam int         LIMIT_6H_MIN         = 360;
    localparam int         LIMIT_9H_MIN         = 540;
    localparam int         TICK_PERIOD_S        = 1;
    localparam int         CLK_HZ               = 100_000_000;
    localparam int         TICK_CYCLES_DEFAULT  = CLK_HZ * TICK_PERIOD_S;
    localparam logic [15:0] LIMIT_45MIN_TICKS   = 16'(LIMIT_45MIN_MIN * 60 / TICK_PERIOD_S);
    localparam logic [15:0] LIMIT_6H_TICKS      = 16'(LIMIT_6H_MIN * 60 / TICK_PERIOD_S);
    localparam logic [15:0] LIMIT_9H_TICKS      = 16'(LIMIT_9H_MIN * 60 / TICK_PERIOD_S);

    // Arbitrary default serial address
    localparam logic [6:0] DEVICE_ADDR_DEFAULT  = 7'h2b;
    localparam logic [3:0] BYTE_BITS            = 4'h8;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_REG,
        S_WDATA,
        S_RDATA
    } serial_state_t;

endpackage

// ---- safety_timer.sv ----
// Fast-charge safety timer with selectable limit and half-speed mode
module safety_timer
    import charger_regs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic       half_speed,
    input  wire logic [1:0] limit_sel,
    output logic            expired,
    output logic            disabled
);

    logic [31:0] pre_ff;
    logic [31:0] nxt_pre;
    logic        half_ff;
    logic        nxt_half;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        exp_ff;
    logic        nxt_exp;
    logic [15:0] limit;

    always_comb begin
        case (limit_sel)
            LIMIT_45MIN: limit = LIMIT_45MIN_TICKS;
            LIMIT_6H:    limit = LIMIT_6H_TICKS;
            default:     limit = LIMIT_9H_TICKS;
        endcase
        nxt_pre  = pre_ff;
        nxt_half = half_ff;
        nxt_cnt  = cnt_ff;
        nxt_exp  = exp_ff;
        if (!run || limit_sel == LIMIT_OFF) begin
            nxt_pre  = 32'h0;
            nxt_half = 1'b0;
            nxt_cnt  = 16'h0;
            nxt_exp  = 1'b0;
        end else if (pre_ff == TICK_CYCLES - 1) begin
            nxt_pre  = 32'h0;
            nxt_half = half_speed ? ~half_ff : 1'b0;
            // Half speed counts every second tick
            if ((!half_speed || half_ff) && cnt_ff < limit) begin
                nxt_cnt = cnt_ff + 16'h1;
            end
            nxt_exp = exp_ff | (cnt_ff >= limit);
        end else begin
            nxt_pre = pre_ff + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pre_ff  <= 32'h0;
            half_ff <= 1'b0;
            cnt_ff  <= 16'h0;
            exp_ff  <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            half_ff <= nxt_half;
            cnt_ff  <= nxt_cnt;
            exp_ff  <= nxt_exp;
        end
    end

    assign expired  = exp_ff;
    assign disabled = (limit_sel == LIMIT_OFF);

endmodule

// ---- thermistor_status.sv ----
// Encodes thermistor comparator levels into the fault code and charge limits
module thermistor_status
    import charger_regs_pkg::*;
#(
    parameter bit EXTENDED_COLD = 1'b0
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       monitor_disable,
    input  wire logic       ts_open,
    input  wire logic       ts_cold,
    input  wire logic       ts_freeze,
    output logic [2:0]      fault_code,
    output logic            charge_suspend,
    output logic            charge_reduce
);

    logic [2:0] code_ff;
    logic [2:0] nxt_code;

    always_comb begin
        if (monitor_disable || ts_open) begin
            nxt_code = TS_OPEN;
        end else if (EXTENDED_COLD && ts_freeze) begin
            nxt_code = TS_BELOW_FREEZE;
        end else if (EXTENDED_COLD && ts_cold) begin
            nxt_code = TS_COLD_ZONE;
        end else if (ts_cold) begin
            nxt_code = TS_BELOW_COLD;
        end else begin
            nxt_code = TS_NORMAL;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            code_ff <= TS_OPEN;
        end else begin
            code_ff <= nxt_code;
        end
    end

    assign fault_code     = code_ff;
    assign charge_suspend = (code_ff == TS_BELOW_COLD) || (code_ff == TS_BELOW_FREEZE);
    assign charge_reduce  = (code_ff == TS_COLD_ZONE);

endmodule

// ---- charger_timer_ovp_control_regs.sv ----
// Serial-accessed timer, thermistor, over-voltage and test control registers
// Functional notes
// - Timer/thermistor register resets to 1010 1xxx; x bits show live status.
// - Slow-down bit 1 halves timer speed in thermal, input or power-path regulation.
// - Limit field: 00 0.75h, 01 6h default, 10 9h, 11 timers disabled.
// - Disconnect bit 1 opens battery switch when input power is removed.
// - Thermistor bit 1 disables monitoring; 0 keeps it active.
// - Status 000 means no fault; 111 means input open or monitoring disabled.
// - Status 100 below cold limit, standard profile only; charging suspended.
// - Extended variant: 101 cold zone reduced charge, 110 below freeze suspended.
// - Over-voltage register resets 0x20 host variant, 0xe0 pin variant.
// - Three-bit field selects over-voltage threshold from 6.0V to 10.5V.
// - D+ release bit 0 keeps D+ source on in dead-battery charging; 1 frees it.
// - Detection runs on termination or test mode; forced bit 1 runs it anyway.
// - Forced detection reports battery presence once the routine has run.
// - Test request enters production test mode, only if the fused enable is 1.
// - Production test mode is refused if a battery is present when the request first arrives.
module charger_timer_ovp_control_regs
    import charger_regs_pkg::*;
#(
    parameter bit          PIN_CONFIGURED = 1'b0,
    parameter bit          EXTENDED_COLD  = 1'b0,
    parameter int unsigned TICK_CYCLES    = TICK_CYCLES_DEFAULT,
    parameter logic [6:0]  DEVICE_ADDR    = DEVICE_ADDR_DEFAULT
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       thermal_regulation,
    input  wire logic       input_voltage_regulation,
    input  wire logic       power_path_regulation,
    input  wire logic       fast_charge_active,
    input  wire logic       input_present,
    input  wire logic       ts_open,
    input  wire logic       ts_cold,
    input  wire logic       ts_freeze,
    input  wire logic       dead_battery_charging,
    input  wire logic       termination,
    input  wire logic       battery_present,
    input  wire logic       battery_detect_done,
    input  wire logic       fused_test_enable,
    output logic            timer_half_speed,
    output logic            safety_timer_expired,
    output logic            safety_timers_disabled,
    output logic            battery_switch_off,
    output logic            thermistor_monitor_enable,
    output logic [2:0]      thermistor_fault_code,
    output logic            charge_suspend,
    output logic            charge_reduce,
    output logic [2:0]      input_overvoltage_threshold,
    output logic            dplus_source_on,
    output logic            battery_detect_run,
    output logic            production_test_mode,
    output logic            input_limit_disable
);

    localparam int ASYNC_W = 15;

    // Input synchronisers
    logic [ASYNC_W-1:0] async_in;
    logic [ASYNC_W-1:0] meta_ff;
    logic [ASYNC_W-1:0] sync_ff;

    assign async_in = {scl_in, sda_in, thermal_regulation, input_voltage_regulation,
                       power_path_regulation, fast_charge_active, input_present, ts_open,
                       ts_cold, ts_freeze, dead_battery_charging, termination,
                       battery_present, battery_detect_done, fused_test_enable};

    genvar gi;
    generate
        for (gi = 0; gi < ASYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    logic scl_s;
    logic sda_s;
    logic thermal_s;
    logic vin_reg_s;
    logic power_path_regulation_s;
    logic fast_s;
    logic input_s;
    logic ts_open_s;
    logic ts_cold_s;
    logic ts_freeze_s;
    logic dbc_s;
    logic term_s;
    logic bat_s;
    logic det_done_s;
    logic fused_s;

    assign {scl_s, sda_s, thermal_s, vin_reg_s, power_path_regulation_s, fast_s, input_s, ts_open_s,
            ts_cold_s, ts_freeze_s, dbc_s, term_s, bat_s, det_done_s, fused_s} = sync_ff;

    // Register storage and derived state
    logic [7:0] tmr_ff;
    logic [7:0] nxt_tmr;
    logic [7:0] ovp_ff;
    logic [7:0] nxt_ovp;
    logic       bat_seen_ff;
    logic       nxt_bat_seen;
    logic       refused_ff;
    logic       nxt_refused;
    logic       ptm_ff;
    logic       nxt_ptm;
    logic       det_run_ff;
    logic       nxt_det_run;
    logic       sw_off_ff;
    logic       nxt_sw_off;
    logic       half_ff;
    logic       nxt_half;
    logic [2:0] ts_code;

    // Serial interface state
    serial_state_t st_ff;
    serial_state_t nxt_st;
    logic [3:0]    cnt_ff;
    logic [3:0]    nxt_cnt;
    logic [7:0]    shift_ff;
    logic [7:0]    nxt_shift;
    logic [7:0]    ptr_ff;
    logic [7:0]    nxt_ptr;
    logic          ack_ff;
    logic          nxt_ack;
    logic          rw_ff;
    logic          nxt_rw;
    logic          nack_ff;
    logic          nxt_nack;
    logic          oe_ff;
    logic          nxt_oe;
    logic          scl_d_ff;
    logic          sda_d_ff;
    logic          wr_stb;

    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        if (addr == TMR_THERM_ADDR) begin
            val = {tmr_ff[7:3], ts_code};
        end else if (addr == OVP_TEST_ADDR) begin
            val = ovp_ff;
            // Reads back presence once a forced detection has finished
            val[BATDET_BIT] = ovp_ff[BATDET_BIT] | bat_seen_ff;
        end
        return val;
    endfunction

    wire start_c = scl_s && sda_d_ff && !sda_s;
    wire stop_c  = scl_s && !sda_d_ff && sda_s;
    wire rise_c  = scl_s && !scl_d_ff;
    wire fall_c  = !scl_s && scl_d_ff;

    always_comb begin
        nxt_st    = st_ff;
        nxt_cnt   = cnt_ff;
        nxt_shift = shift_ff;
        nxt_ptr   = ptr_ff;
        nxt_ack   = ack_ff;
        nxt_rw    = rw_ff;
        nxt_nack  = nack_ff;
        nxt_oe    = oe_ff;
        wr_stb    = 1'b0;
        if (start_c) begin
            nxt_st  = S_ADDR;
            nxt_cnt = 4'h0;
            nxt_ack = 1'b0;
            nxt_oe  = 1'b0;
        end else if (stop_c) begin
            nxt_st = S_IDLE;
            nxt_oe = 1'b0;
        end else if (st_ff != S_IDLE) begin
            if (rise_c && !ack_ff) begin
                nxt_shift = {shift_ff[6:0], sda_s};
                nxt_cnt   = cnt_ff + 4'h1;
            end
            if (rise_c && ack_ff) begin
                nxt_nack = sda_s;
            end
            if (fall_c && !ack_ff && cnt_ff == BYTE_BITS) begin
                nxt_ack = 1'b1;
                nxt_oe  = 1'b1;
                case (st_ff)
                    S_ADDR: begin
                        nxt_rw = shift_ff[0];
                        if (shift_ff[7:1] != DEVICE_ADDR) begin
                            nxt_st = S_IDLE;
                            nxt_oe = 1'b0;
                        end
                    end
                    S_REG:   nxt_ptr = shift_ff;
                    S_WDATA: wr_stb = 1'b1;
                    default: nxt_oe = 1'b0;
                endcase
            end else if (fall_c && ack_ff) begin
                nxt_ack = 1'b0;
                nxt_cnt = 4'h0;
                nxt_oe  = 1'b0;
                case (st_ff)
                    S_ADDR: begin
                        if (rw_ff) begin
                            nxt_st    = S_RDATA;
                            nxt_shift = reg_read(ptr_ff);
                            nxt_oe    = ~nxt_shift[7];
                            nxt_ptr   = ptr_ff + 8'h1;
                        end else begin
                            nxt_st = S_REG;
                        end
                    end
                    S_REG:   nxt_st = S_WDATA;
                    S_WDATA: nxt_ptr = ptr_ff + 8'h1;
                    S_RDATA: begin
                        if (nack_ff) begin
                            nxt_st = S_IDLE;
                        end else begin
                            nxt_shift = reg_read(ptr_ff);
                            nxt_oe    = ~nxt_shift[7];
                            nxt_ptr   = ptr_ff + 8'h1;
                        end
                    end
                    default: nxt_st = S_IDLE;
                endcase
            end else if (fall_c && st_ff == S_RDATA) begin
                // Open drain: enable pulls the line low for a zero bit
                nxt_oe = ~shift_ff[7];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_ff    <= S_IDLE;
            cnt_ff   <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff   <= 8'h00;
            ack_ff   <= 1'b0;
            rw_ff    <= 1'b0;
            nack_ff  <= 1'b0;
            oe_ff    <= 1'b0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            shift_ff <= nxt_shift;
            ptr_ff   <= nxt_ptr;
            ack_ff   <= nxt_ack;
            rw_ff    <= nxt_rw;
            nack_ff  <= nxt_nack;
            oe_ff    <= nxt_oe;
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    wire wr_tmr = wr_stb && ptr_ff == TMR_THERM_ADDR;
    wire wr_ovp = wr_stb && ptr_ff == OVP_TEST_ADDR;

    always_comb begin
        nxt_tmr      = tmr_ff;
        nxt_ovp      = ovp_ff;
        nxt_bat_seen = bat_seen_ff;
        nxt_refused  = refused_ff;
        if (wr_tmr) begin
            nxt_tmr[7:3] = shift_ff[7:3];
        end
        // Forced detection clears when the routine ends; a new write wins
        if (det_done_s && ovp_ff[BATDET_BIT]) begin
            nxt_ovp[BATDET_BIT] = 1'b0;
            nxt_bat_seen        = bat_s;
        end
        if (wr_ovp) begin
            nxt_ovp = shift_ff;
            if (shift_ff[BATDET_BIT]) begin
                nxt_bat_seen = 1'b0;
            end
            // Battery state is judged when the request first arrives
            if (shift_ff[TEST_REQ_BIT] && !ovp_ff[TEST_REQ_BIT]) begin
                nxt_refused = bat_s;
            end
        end
        nxt_ptm     = ovp_ff[TEST_REQ_BIT] && fused_s && !refused_ff;
        nxt_det_run = ovp_ff[BATDET_BIT] || term_s || ptm_ff;
        nxt_sw_off  = tmr_ff[DISCONNECT_BIT] && !input_s;
        nxt_half    = tmr_ff[SLOWDOWN_BIT] && (thermal_s || vin_reg_s || power_path_regulation_s);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tmr_ff      <= TMR_THERM_RESET;
            ovp_ff      <= PIN_CONFIGURED ? OVP_TEST_RESET_PIN : OVP_TEST_RESET_HOST;
            bat_seen_ff <= 1'b0;
            refused_ff  <= 1'b0;
            ptm_ff      <= 1'b0;
            det_run_ff  <= 1'b0;
            sw_off_ff   <= 1'b0;
            half_ff     <= 1'b0;
        end else begin
            tmr_ff      <= nxt_tmr;
            ovp_ff      <= nxt_ovp;
            bat_seen_ff <= nxt_bat_seen;
            refused_ff  <= nxt_refused;
            ptm_ff      <= nxt_ptm;
            det_run_ff  <= nxt_det_run;
            sw_off_ff   <= nxt_sw_off;
            half_ff     <= nxt_half;
        end
    end

    safety_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .run        (fast_s),
        .half_speed (half_ff),
        .limit_sel  (tmr_ff[LIMIT_HI_BIT:LIMIT_LO_BIT]),
        .expired    (safety_timer_expired),
        .disabled   (safety_timers_disabled)
    );

    thermistor_status #(
        .EXTENDED_COLD (EXTENDED_COLD)
    ) u_therm (
        .clk_sys         (clk_sys),
        .reset_n         (reset_n),
        .monitor_disable (tmr_ff[THERM_DIS_BIT]),
        .ts_open         (ts_open_s),
        .ts_cold         (ts_cold_s),
        .ts_freeze       (ts_freeze_s),
        .fault_code      (ts_code),
        .charge_suspend  (charge_suspend),
        .charge_reduce   (charge_reduce)
    );

    assign sda_out                     = 1'b0;
    assign sda_oe                      = oe_ff;
    assign timer_half_speed            = half_ff;
    assign battery_switch_off          = sw_off_ff;
    assign thermistor_monitor_enable   = ~tmr_ff[THERM_DIS_BIT];
    assign thermistor_fault_code       = ts_code;
    assign input_overvoltage_threshold = ovp_ff[OVP_MSB:OVP_LSB];
    assign dplus_source_on             = dbc_s && !ovp_ff[DPLUS_BIT];
    assign battery_detect_run          = det_run_ff;
    assign production_test_mode        = ptm_ff;
    assign input_limit_disable         = ptm_ff;

endmodule

// ---- host_master.sv ----
// Host controller model on the open-drain serial register interface
module host_master
    import charger_regs_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl_in,
    output logic      sda_rel
);
    int nacks = 0;
    initial begin
        scl_in = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Each SCL phase is 10 clocks, above the 8-clock minimum
    task automatic bitx(logic b, output logic r);
        sda_rel = b;
        tick(10);
        scl_in = 1'b1;
        tick(5);
        r = sda_line;
        tick(5);
        scl_in = 1'b0;
    endtask
    task automatic xfer(logic [7:0] d, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, k);
        if (k !== 1'b0 && d !== 8'hff) nacks++;
    endtask
    task automatic start();
        sda_rel = 1'b1;
        tick(10);
        scl_in = 1'b1;
        tick(10);
        sda_rel = 1'b0;
        tick(10);
        scl_in = 1'b0;
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        tick(10);
        scl_in = 1'b1;
        tick(10);
        sda_rel = 1'b1;
        tick(10);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({DEVICE_ADDR_DEFAULT, 1'b0}, q);
        xfer(a, q);
        xfer(d, q);
        stop();
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({DEVICE_ADDR_DEFAULT, 1'b0}, q);
        xfer(a, q);
        start();
        xfer({DEVICE_ADDR_DEFAULT, 1'b1}, q);
        xfer(8'hff, d);
        stop();
    endtask
endmodule

// ---- regs_sva.sv ----
// Port-level checker for the charger control register bank
module regs_sva (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       sda_out,
    input wire logic       input_present,
    input wire logic       battery_switch_off,
    input wire logic       thermistor_monitor_enable,
    input wire logic       ts_open,
    input wire logic [2:0] thermistor_fault_code,
    input wire logic       charge_suspend,
    input wire logic       charge_reduce,
    input wire logic       dead_battery_charging,
    input wire logic       dplus_source_on,
    input wire logic       termination,
    input wire logic       battery_detect_run,
    input wire logic       fused_test_enable,
    input wire logic       production_test_mode,
    input wire logic       input_limit_disable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda_out driven high");
    a_switch_with_input: assert property (input_present [*5] |-> !battery_switch_off)
        else $error("battery switch off with input present");
    a_ts_disabled_code: assert property (!thermistor_monitor_enable [*5] |->
        thermistor_fault_code == 3'h7)
        else $error("disabled monitor not coded 111");
    a_ts_open_code: assert property ((ts_open && thermistor_monitor_enable) [*5] |->
        thermistor_fault_code == 3'h7)
        else $error("open thermistor not coded 111");
    a_cold_suspends: assert property (thermistor_fault_code == 3'h4 |->
        charge_suspend && !charge_reduce)
        else $error("cold code without suspend");
    a_dplus_needs_dbp: assert property (!dead_battery_charging [*5] |-> !dplus_source_on)
        else $error("D+ source on outside dead-battery charging");
    a_term_detects: assert property (termination [*5] |-> battery_detect_run)
        else $error("no detection on termination");
    a_fuse_gates_test: assert property (!fused_test_enable [*5] |-> !production_test_mode)
        else $error("test mode without fused enable");
    a_test_ilim_off: assert property (input_limit_disable == production_test_mode)
        else $error("input limit not following test mode");
    c_test_mode: cover property (production_test_mode);
    c_switch_off: cover property (battery_switch_off);
    c_cold: cover property (charge_suspend);
endmodule

bind charger_timer_ovp_control_regs regs_sva u_sva (.*);

// ---- testbench.sv ----
// Self-checking bench for the charger control register bank
module testbench
    import charger_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys = 1'b0, reset_n = 1'b0, scl_in, sda_rel, sda_out, sda_oe;
    logic       thermal_regulation, input_voltage_regulation;
    logic       power_path_regulation, fast_charge_active;
    logic       input_present = 1'b1, ts_open, ts_cold, ts_freeze = 1'b0;
    logic       dead_battery_charging, termination, battery_present;
    logic       battery_detect_done, fused_test_enable;
    logic       timer_half_speed, safety_timer_expired, safety_timers_disabled;
    logic       battery_switch_off, thermistor_monitor_enable, charge_suspend, charge_reduce;
    logic       dplus_source_on, battery_detect_run, production_test_mode, input_limit_disable;
    logic [2:0] thermistor_fault_code, input_overvoltage_threshold;
    wire        sda_in = sda_rel & ~sda_oe;
    int         err_count = 0;
    int         n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    // Short tick so the 45-minute limit fits in about 11k cycles
    charger_timer_ovp_control_regs #(.TICK_CYCLES(4)) dut (.*);
    host_master host (.clk_sys(clk_sys), .sda_line(sda_in), .scl_in(scl_in), .sda_rel(sda_rel));
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(logic [7:0] a, logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk("readback", e, d);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1_000_000;
        err_count++;
        test_done();
    end
    initial begin
        {thermal_regulation, input_voltage_regulation, power_path_regulation, ts_open} = '0;
        {fast_charge_active, ts_cold, dead_battery_charging, termination, battery_present} = '0;
        {battery_detect_done, fused_test_enable} = '0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        host.tick(2);
        rc(TMR_THERM_ADDR, 8'haf);
        rc(OVP_TEST_ADDR, OVP_TEST_RESET_HOST);
        rc(8'h07, 8'h00);
        chk("threshold", 8'h1, input_overvoltage_threshold);
        for (int l = 0; l < 4; l++) begin
            host.wr(TMR_THERM_ADDR, 8'(l << 5));
            chk("timers_off", 8'(l == 3), safety_timers_disabled);
        end
        thermal_regulation = 1'b1;
        host.tick(8);
        chk("half_speed", 8'h0, timer_half_speed);
        host.wr(TMR_THERM_ADDR, 8'h80);
        chk("half_speed", 8'h1, timer_half_speed);
        thermal_regulation = 1'b0;
        fast_charge_active = 1'b1;
        host.tick(8);
        chk("half_speed", 8'h0, timer_half_speed);
        host.tick(10000);
        chk("expired", 8'h0, safety_timer_expired);
        host.tick(1000);
        chk("expired", 8'h1, safety_timer_expired);
        host.wr(TMR_THERM_ADDR, 8'h60);
        chk("expired", 8'h0, safety_timer_expired);
        fast_charge_active = 1'b0;
        $display("test timer done");
        ts_cold = 1'b1;
        host.tick(8);
        chk("ts_code", TS_BELOW_COLD, thermistor_fault_code);
        ts_cold = 1'b0;
        ts_open = 1'b1;
        host.tick(8);
        chk("ts_code", TS_OPEN, thermistor_fault_code);
        ts_open = 1'b0;
        host.tick(8);
        chk("ts_code", TS_NORMAL, thermistor_fault_code);
        host.wr(TMR_THERM_ADDR, 8'h08);
        chk("ts_on", 8'h0, thermistor_monitor_enable);
        host.wr(TMR_THERM_ADDR, 8'h77);
        rc(TMR_THERM_ADDR, 8'h70);
        input_present = 1'b0;
        host.tick(8);
        chk("switch_off", 8'h1, battery_switch_off);
        input_present = 1'b1;
        $display("test thermistor done");
        for (int v = 0; v < 8; v++) begin
            host.wr(OVP_TEST_ADDR, 8'(v << 5) | 8'(v & 3));
            chk("threshold", 8'(v), input_overvoltage_threshold);
            rc(OVP_TEST_ADDR, 8'(v << 5) | 8'(v & 3));
        end
        dead_battery_charging = 1'b1;
        host.tick(8);
        chk("dplus_on", 8'h1, dplus_source_on);
        host.wr(OVP_TEST_ADDR, 8'h10);
        chk("dplus_on", 8'h0, dplus_source_on);
        $display("test overvoltage done");
        battery_present = 1'b1;
        host.wr(OVP_TEST_ADDR, 8'h08);
        chk("detect_run", 8'h1, battery_detect_run);
        battery_detect_done = 1'b1;
        host.tick(4);
        battery_detect_done = 1'b0;
        host.tick(8);
        chk("detect_run", 8'h0, battery_detect_run);
        rc(OVP_TEST_ADDR, 8'h08);
        termination = 1'b1;
        host.tick(8);
        termination = 1'b0;
        fused_test_enable = 1'b1;
        host.wr(OVP_TEST_ADDR, 8'h04);
        chk("test_mode", 8'h0, production_test_mode);
        host.wr(OVP_TEST_ADDR, 8'h00);
        battery_present = 1'b0;
        host.wr(OVP_TEST_ADDR, 8'h04);
        chk("test_mode", 8'h1, production_test_mode);
        fused_test_enable = 1'b0;
        host.tick(8);
        chk("test_mode", 8'h0, production_test_mode);
        chk("nacks", 8'h0, 8'(host.nacks));
        $display("test test_mode done");
        test_done();
    end
endmodule
